// File: core/fhri_pkg.sv
// Purpose: constants and carriers for the floppy host register interface
// Assumes: one clock mclk, synchronous active-high reset srst
// Notes: host bus strobes are one-cycle pulses, synchronous to mclk
// Operation
// - ready bit set only when port usable
// - direction bit: 1 device-to-host, 0 host-to-device
// - execution bit only in non-dma execution
// - busy bit during command, blocks new commands
// - seek bits per drive, refuse commands
// - writes to status address are ignored unless dack is set
// - one data port, results from stack
// - status 0 top bits give termination
// - status 0 seek end, fault, head, unit
// - status 1 end, crc, overrun; 6,3 zero
// - status 1 missing sector, protect, no mark
// - status 2 deleted, crc, cylinder, bit7 zero
// - status 2 scan hit, unmet, no mark
// - status 3 mirrors live drive lines
// - drive control: motors, enable, reset, select
// - drive active when selected and motor on
// - rate bits pick prescaler 3, 5, 6
// - input register bit7 inverted change, rest floating
// - fifteen commands, fourteen multi-byte, three phases
// - dma request per byte, interrupt at end
// - non-dma interrupt per byte, cleared on access
package fhri_pkg;

    localparam logic [9:0] FHRI_DOR_ADDR = 10'h3f2;
    localparam logic [9:0] FHRI_MSR_ADDR = 10'h3f4;
    localparam logic [9:0] FHRI_DATA_ADDR = 10'h3f5;
    localparam logic [9:0] FHRI_RATE_ADDR = 10'h3f7;

    localparam int FHRI_MSR_RQM = 7;
    localparam int FHRI_MSR_DIO = 6;
    localparam int FHRI_MSR_EXM = 5;
    localparam int FHRI_MSR_BUSY = 4;
    localparam int FHRI_DOR_EN = 3;
    localparam int FHRI_DOR_RST = 2;

    localparam logic [7:0] FHRI_DOR_RESET = 8'h00;
    localparam logic [1:0] FHRI_RATE_RESET = 2'h0;
    localparam logic FHRI_NONDMA_RESET = 1'b1;

    localparam logic [2:0] FHRI_DIV_8M = 3'h3;
    localparam logic [2:0] FHRI_DIV_4M8 = 3'h5;
    localparam logic [2:0] FHRI_DIV_4M = 3'h6;

    localparam logic [1:0] FHRI_IC_INVALID = 2'h2;
    localparam logic [1:0] FHRI_IC_READY_CHG = 2'h3;
    localparam logic [7:0] FHRI_ST0_INVALID = 8'h80;
    localparam logic [2:0] FHRI_RES_LEN_DATA = 3'h7;

    localparam logic [4:0] FHRI_OP_READ_TRACK = 5'h02;
    localparam logic [4:0] FHRI_OP_SPECIFY = 5'h03;
    localparam logic [4:0] FHRI_OP_SENSE_DRIVE = 5'h04;
    localparam logic [4:0] FHRI_OP_WRITE = 5'h05;
    localparam logic [4:0] FHRI_OP_READ = 5'h06;
    localparam logic [4:0] FHRI_OP_RECAL = 5'h07;
    localparam logic [4:0] FHRI_OP_SENSE_INT = 5'h08;
    localparam logic [4:0] FHRI_OP_WRITE_DEL = 5'h09;
    localparam logic [4:0] FHRI_OP_READ_ID = 5'h0a;
    localparam logic [4:0] FHRI_OP_READ_DEL = 5'h0c;
    localparam logic [4:0] FHRI_OP_FORMAT = 5'h0d;
    localparam logic [4:0] FHRI_OP_SEEK = 5'h0f;
    localparam logic [4:0] FHRI_OP_SCAN_EQ = 5'h11;
    localparam logic [4:0] FHRI_OP_SCAN_LE = 5'h19;
    localparam logic [4:0] FHRI_OP_SCAN_HE = 5'h1d;

    typedef enum logic [1:0] {
        PH_CMD,
        PH_EXEC,
        PH_RES
    } fhri_phase_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic dack;
        logic [9:0] addr;
        logic [7:0] wdata;
    } fhri_host_req_t;

    typedef struct packed {
        logic fault;
        logic write_protect;
        logic drive_ready_input;
        logic track_zero_input;
        logic two_sided_input;
    } fhri_drive_in_t;

    typedef struct packed {
        logic [7:0] st0;
        logic [7:0] st1;
        logic [7:0] st2;
        logic [7:0] c;
        logic [7:0] h;
        logic [7:0] r;
        logic [7:0] n;
    } fhri_result_t;

endpackage

// File: core/fhri_top.sv
// Purpose: host register port, phase sequencer and status stack
// Assumes: command execution core sits behind the core_* ports
// Notes: all outputs registered; answers one cycle after the strobe
`timescale 1ns/1ps
module fhri_top (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // host bus
    input wire fhri_pkg::fhri_host_req_t host_req,
    output logic [7:0] host_rdata,
    output logic [7:0] host_rdata_oe,
    output logic dma_req,
    output logic irq,
    // drive lines
    input wire fhri_pkg::fhri_drive_in_t drv_in,
    input wire logic disk_change,
    output logic [3:0] motor_on,
    output logic [3:0] drive_active,
    output logic unit_bit0,
    output logic unit_bit1,
    output logic side_select_output,
    // execution core
    output logic core_clk_en,
    output logic core_reset,
    output logic exec_start,
    output logic [71:0] exec_cmd,
    output logic core_overrun,
    output logic core_wbyte_valid,
    output logic [7:0] core_wbyte,
    input wire logic core_rbyte_valid,
    input wire logic [7:0] core_rbyte,
    input wire logic core_wreq,
    input wire logic core_done,
    input wire fhri_pkg::fhri_result_t core_result,
    input wire logic [3:0] core_seek_busy,
    input wire logic core_seek_end
);
    import fhri_pkg::*;

    function automatic logic [3:0] cmd_len_f(input logic [4:0] op);
        case (op)
            FHRI_OP_READ_TRACK, FHRI_OP_WRITE, FHRI_OP_READ, FHRI_OP_WRITE_DEL,
            FHRI_OP_READ_DEL, FHRI_OP_SCAN_EQ, FHRI_OP_SCAN_LE, FHRI_OP_SCAN_HE: cmd_len_f = 4'h9;
            FHRI_OP_FORMAT: cmd_len_f = 4'h6;
            FHRI_OP_SPECIFY, FHRI_OP_SEEK: cmd_len_f = 4'h3;
            FHRI_OP_SENSE_DRIVE, FHRI_OP_RECAL, FHRI_OP_READ_ID: cmd_len_f = 4'h2;
            FHRI_OP_SENSE_INT: cmd_len_f = 4'h1;
            default: cmd_len_f = 4'h0;
        endcase
    endfunction

    function automatic logic is_read_dir_f(input logic [4:0] op);
        is_read_dir_f = (op == FHRI_OP_READ_TRACK) || (op == FHRI_OP_READ) ||
                        (op == FHRI_OP_READ_ID) || (op == FHRI_OP_READ_DEL);
    endfunction

    function automatic fhri_result_t clean_f(input fhri_result_t r, input logic rchg, input logic ovr,
                                             input logic head, input logic [1:0] unit);
        clean_f = r;
        if (rchg) begin
            clean_f.st0[7:6] = FHRI_IC_READY_CHG;
        end
        clean_f.st0[3] = 1'b0;
        clean_f.st0[2] = head;
        clean_f.st0[1:0] = unit;
        clean_f.st1[6] = 1'b0;
        clean_f.st1[4] = r.st1[4] | ovr;
        clean_f.st1[3] = 1'b0;
        clean_f.st2[7] = 1'b0;
        clean_f.st2[1] = r.st2[1] & r.st2[4];
    endfunction

    fhri_phase_t phase;
    logic [7:0] dor;
    logic [1:0] rate;
    logic nondma;
    logic [3:0] cmd_cnt;
    logic [4:0] cmd_op;
    logic [7:0] cmd_buf [0:8];
    logic [7:0] res_buf [0:6];
    logic [2:0] res_cnt;
    logic [2:0] res_len;
    logic exec_rd;
    logic xfer_full;
    logic [7:0] xfer_data;
    logic want_byte;
    logic ovr_flag;
    logic ready_cap;
    logic ready_chg;
    logic int_pend;
    logic seek_int;
    logic [7:0] seek_st0;
    logic [7:0] seek_pcn;
    logic [2:0] div_cnt;
    logic [3:0] seek_q;

    logic ctl_rst;
    logic dp_rd;
    logic dp_wr;
    logic host_transfer_ready;
    logic seek_any;
    logic [7:0] msr;
    logic [4:0] op_now;
    logic [3:0] len_now;
    logic cmd_take;
    logic cmd_last;
    logic [71:0] next_exec_cmd;
    logic [7:0] st3_live;
    logic [2:0] div_val;
    fhri_result_t res_clean;

    assign ctl_rst = srst | dor[FHRI_DOR_RST];
    assign seek_any = |seek_q;
    // single data port, dma acknowledge also reaches it
    assign dp_rd = host_req.rd & (host_req.dack | (host_req.addr == FHRI_DATA_ADDR));
    // status address reaches the data port only under dma acknowledge
    assign dp_wr = host_req.wr & (host_req.dack | (host_req.addr == FHRI_DATA_ADDR));
    assign op_now = (cmd_cnt == 4'h0) ? host_req.wdata[4:0] : cmd_op;
    assign len_now = cmd_len_f(op_now);
    assign st3_live = {drv_in.fault, drv_in.write_protect, drv_in.drive_ready_input, drv_in.track_zero_input,
                       drv_in.two_sided_input, side_select_output, unit_bit1, unit_bit0};
    assign res_clean = clean_f(core_result, ready_chg, ovr_flag, side_select_output, {unit_bit1, unit_bit0});

    always_comb begin
        host_transfer_ready = 1'b0;
        case (phase)
            PH_CMD: host_transfer_ready = ~seek_any & ~ctl_rst;
            PH_EXEC: host_transfer_ready = exec_rd ? xfer_full : want_byte;
            PH_RES: host_transfer_ready = 1'b1;
            default: host_transfer_ready = 1'b0;
        endcase
        msr = {4'h0, seek_q};
        msr[FHRI_MSR_RQM] = host_transfer_ready;
        msr[FHRI_MSR_DIO] = (phase == PH_RES) | ((phase == PH_EXEC) & exec_rd);
        msr[FHRI_MSR_EXM] = (phase == PH_EXEC) & nondma;
        msr[FHRI_MSR_BUSY] = (phase != PH_CMD) | (cmd_cnt != 4'h0);
    end

    assign cmd_take = dp_wr & (phase == PH_CMD) & host_transfer_ready;
    assign cmd_last = cmd_take & ((len_now == 4'h0) || ({1'b0, cmd_cnt} + 5'h01 == {1'b0, len_now}));

    always_comb begin
        next_exec_cmd = '0;
        for (int i = 0; i < 9; i++) begin
            next_exec_cmd[i*8 +: 8] = (i == int'(cmd_cnt)) ? host_req.wdata : cmd_buf[i];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            dor <= FHRI_DOR_RESET;
            rate <= FHRI_RATE_RESET;
        end else if (host_req.wr && !host_req.dack) begin
            if (host_req.addr == FHRI_DOR_ADDR) begin
                dor <= host_req.wdata;
            end else if (host_req.addr == FHRI_RATE_ADDR) begin
                rate <= host_req.wdata[1:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            motor_on <= 4'h0;
            drive_active <= 4'h0;
            unit_bit0 <= 1'b0;
            unit_bit1 <= 1'b0;
        end else begin
            motor_on <= dor[7:4];
            drive_active <= dor[7:4] & (4'h1 << dor[1:0]);
            unit_bit0 <= dor[0];
            unit_bit1 <= dor[1];
        end
    end

    always_comb begin
        case (rate)
            2'h1: div_val = FHRI_DIV_4M8;
            2'h2: div_val = FHRI_DIV_4M;
            default: div_val = FHRI_DIV_8M;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            div_cnt <= 3'h0;
            core_clk_en <= 1'b0;
        end else if (div_cnt + 3'h1 >= div_val) begin
            div_cnt <= 3'h0;
            core_clk_en <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 3'h1;
            core_clk_en <= 1'b0;
        end
    end

    // seek busy is registered once; a seek can not end faster than that
    always_ff @(posedge mclk) begin
        if (ctl_rst) begin
            seek_q <= 4'h0;
            core_reset <= 1'b1;
        end else begin
            seek_q <= core_seek_busy;
            core_reset <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (ctl_rst) begin
            phase <= PH_CMD;
            cmd_cnt <= 4'h0;
            cmd_op <= 5'h0;
            res_cnt <= 3'h0;
            res_len <= 3'h0;
            exec_rd <= 1'b0;
            exec_start <= 1'b0;
            exec_cmd <= '0;
            nondma <= FHRI_NONDMA_RESET;
            side_select_output <= 1'b0;
            for (int i = 0; i < 9; i++) begin
                cmd_buf[i] <= 8'h0;
            end
            for (int i = 0; i < 7; i++) begin
                res_buf[i] <= 8'h0;
            end
        end else begin
            exec_start <= 1'b0;
            if (cmd_take) begin
                cmd_buf[cmd_cnt] <= host_req.wdata;
                cmd_op <= op_now;
                cmd_cnt <= cmd_last ? 4'h0 : cmd_cnt + 4'h1;
            end
            if (cmd_last) begin
                if (len_now == 4'h0) begin
                    res_buf[0] <= FHRI_ST0_INVALID;
                    res_len <= 3'h1;
                    res_cnt <= 3'h0;
                    phase <= PH_RES;
                end else begin
                    case (op_now)
                        FHRI_OP_SPECIFY: nondma <= host_req.wdata[0];
                        FHRI_OP_SENSE_DRIVE: begin
                            res_buf[0] <= st3_live;
                            res_len <= 3'h1;
                            res_cnt <= 3'h0;
                            phase <= PH_RES;
                        end
                        FHRI_OP_SENSE_INT: begin
                            res_buf[0] <= seek_int ? seek_st0 : FHRI_ST0_INVALID;
                            res_buf[1] <= seek_pcn;
                            res_len <= seek_int ? 3'h2 : 3'h1;
                            res_cnt <= 3'h0;
                            phase <= PH_RES;
                        end
                        default: begin
                            exec_start <= 1'b1;
                            exec_cmd <= next_exec_cmd;
                            exec_rd <= is_read_dir_f(op_now);
                            side_select_output <= next_exec_cmd[10];
                            if (op_now != FHRI_OP_SEEK && op_now != FHRI_OP_RECAL) begin
                                phase <= PH_EXEC;
                            end
                        end
                    endcase
                end
            end
            if (phase == PH_EXEC && core_done) begin
                res_buf[0] <= res_clean.st0;
                res_buf[1] <= res_clean.st1;
                res_buf[2] <= res_clean.st2;
                res_buf[3] <= res_clean.c;
                res_buf[4] <= res_clean.h;
                res_buf[5] <= res_clean.r;
                res_buf[6] <= res_clean.n;
                res_len <= FHRI_RES_LEN_DATA;
                res_cnt <= 3'h0;
                phase <= PH_RES;
            end
            if (phase == PH_RES && dp_rd) begin
                if (res_cnt + 3'h1 == res_len) begin
                    phase <= PH_CMD;
                    res_cnt <= 3'h0;
                end else begin
                    res_cnt <= res_cnt + 3'h1;
                end
            end
        end
    end

    // byte handoff; a new byte beats a same-cycle host read
    always_ff @(posedge mclk) begin
        if (ctl_rst) begin
            xfer_full <= 1'b0;
            xfer_data <= 8'h0;
            want_byte <= 1'b0;
            ovr_flag <= 1'b0;
            core_overrun <= 1'b0;
            core_wbyte_valid <= 1'b0;
            core_wbyte <= 8'h0;
        end else begin
            core_overrun <= 1'b0;
            core_wbyte_valid <= 1'b0;
            if (exec_start) begin
                ovr_flag <= 1'b0;
                xfer_full <= 1'b0;
                want_byte <= 1'b0;
            end else if (phase == PH_EXEC) begin
                if (core_rbyte_valid) begin
                    xfer_full <= 1'b1;
                    xfer_data <= core_rbyte;
                    if (xfer_full && !dp_rd) begin
                        ovr_flag <= 1'b1;
                        core_overrun <= 1'b1;
                    end
                end else if (dp_rd && exec_rd) begin
                    xfer_full <= 1'b0;
                end
                if (core_wreq) begin
                    if (want_byte && !dp_wr) begin
                        ovr_flag <= 1'b1;
                        core_overrun <= 1'b1;
                    end
                    want_byte <= 1'b1;
                end else if (dp_wr && want_byte && !exec_rd) begin
                    want_byte <= 1'b0;
                    core_wbyte_valid <= 1'b1;
                    core_wbyte <= host_req.wdata;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (ctl_rst) begin
            ready_cap <= 1'b0;
            ready_chg <= 1'b0;
        end else if (exec_start) begin
            ready_cap <= drv_in.drive_ready_input;
            ready_chg <= 1'b0;
        end else if (phase == PH_EXEC && drv_in.drive_ready_input != ready_cap) begin
            ready_chg <= 1'b1;
        end
    end

    // result-phase and seek interrupts, set wins over clear
    always_ff @(posedge mclk) begin
        if (ctl_rst) begin
            int_pend <= 1'b0;
            seek_int <= 1'b0;
            seek_st0 <= 8'h0;
            seek_pcn <= 8'h0;
        end else begin
            if (phase == PH_EXEC && core_done) begin
                int_pend <= 1'b1;
            end else if (phase == PH_RES && dp_rd) begin
                int_pend <= 1'b0;
            end
            if (core_seek_end) begin
                seek_int <= 1'b1;
                seek_st0 <= {core_result.st0[7:4], 1'b0, core_result.st0[2:0]};
                seek_pcn <= core_result.c;
            end else if (cmd_last && op_now == FHRI_OP_SENSE_INT) begin
                seek_int <= 1'b0;
            end
        end
    end

    // dma request and interrupt pins, gated by enable
    always_ff @(posedge mclk) begin
        if (ctl_rst) begin
            dma_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            dma_req <= dor[FHRI_DOR_EN] & (phase == PH_EXEC) & ~nondma & host_transfer_ready & ~host_req.dack;
            irq <= dor[FHRI_DOR_EN] & (int_pend | seek_int | ((phase == PH_EXEC) & nondma & host_transfer_ready & ~dp_rd & ~dp_wr));
        end
    end

    // read path; bits 6-0 of the input register float
    always_ff @(posedge mclk) begin
        if (srst) begin
            host_rdata <= 8'h0;
            host_rdata_oe <= 8'h0;
        end else if (host_req.rd) begin
            if (dp_rd) begin
                host_rdata <= (phase == PH_RES) ? res_buf[res_cnt] : ((phase == PH_EXEC) ? xfer_data : 8'h0);
                host_rdata_oe <= 8'hff;
            end else if (host_req.addr == FHRI_MSR_ADDR) begin
                host_rdata <= msr;
                host_rdata_oe <= 8'hff;
            end else if (host_req.addr == FHRI_RATE_ADDR) begin
                host_rdata <= {~disk_change, 7'h0};
                host_rdata_oe <= 8'h80;
            end else begin
                host_rdata <= 8'h0;
                host_rdata_oe <= 8'h0;
            end
        end
    end

    sequence s_msr_read;
        host_req.rd && !host_req.dack && host_req.addr == FHRI_MSR_ADDR;
    endsequence

    sequence s_last_byte_done;
        phase == PH_EXEC && core_done && dor[FHRI_DOR_EN] ##1 phase == PH_RES;
    endsequence

    property p_res_handshake;
        @(posedge mclk) disable iff (ctl_rst) s_msr_read and phase == PH_RES |=> host_rdata[7:6] == 2'h3;
    endproperty
    a_res_handshake: assert property (p_res_handshake) else $error("result phase not ready/outward");

    property p_exm;
        @(posedge mclk) disable iff (ctl_rst) msr[FHRI_MSR_EXM] |-> phase == PH_EXEC && nondma;
    endproperty
    a_exm: assert property (p_exm) else $error("execution bit outside non-dma execution");

    property p_seek_refuse;
        @(posedge mclk) disable iff (ctl_rst) seek_any && dp_wr && phase == PH_CMD |=> $stable(cmd_cnt);
    endproperty
    a_seek_refuse: assert property (p_seek_refuse) else $error("command byte taken while seeking");

    property p_msr_write;
        @(posedge mclk) disable iff (ctl_rst)
            host_req.wr && !host_req.dack && host_req.addr == FHRI_MSR_ADDR |=> $stable(cmd_cnt) && $stable(phase);
    endproperty
    a_msr_write: assert property (p_msr_write) else $error("status address write had effect");

    property p_zero_bits;
        @(posedge mclk) disable iff (ctl_rst) s_last_byte_done |-> res_buf[0][3] == 1'b0 && res_buf[1][6] == 1'b0
            && res_buf[1][3] == 1'b0 && res_buf[2][7] == 1'b0;
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("fixed-zero status bit set");

    property p_ready_chg;
        @(posedge mclk) disable iff (ctl_rst) phase == PH_EXEC && core_done && ready_chg |=> res_buf[0][7:6] == 2'h3;
    endproperty
    a_ready_chg: assert property (p_ready_chg) else $error("ready change code missing");

    property p_done_irq;
        @(posedge mclk) disable iff (ctl_rst) s_last_byte_done |=> irq;
    endproperty
    a_done_irq: assert property (p_done_irq) else $error("no interrupt at result phase");

    property p_dma_req;
        @(posedge mclk) disable iff (ctl_rst)
            phase == PH_EXEC && !nondma && dor[FHRI_DOR_EN] && xfer_full && exec_rd && !host_req.dack |=> dma_req;
    endproperty
    a_dma_req: assert property (p_dma_req) else $error("dma request missing");

    property p_nondma_irq;
        @(posedge mclk) disable iff (ctl_rst)
            phase == PH_EXEC && nondma && dor[FHRI_DOR_EN] && host_transfer_ready && !dp_rd && !dp_wr |=> irq;
    endproperty
    a_nondma_irq: assert property (p_nondma_irq) else $error("byte interrupt missing");

    property p_drive_act;
        @(posedge mclk) disable iff (srst) ##1 drive_active == ($past(dor[7:4]) & (4'h1 << $past(dor[1:0])));
    endproperty
    a_drive_act: assert property (p_drive_act) else $error("drive activation wrong");

    property p_change_bit;
        @(posedge mclk) disable iff (srst) host_req.rd && !host_req.dack && host_req.addr == FHRI_RATE_ADDR
            |=> host_rdata[7] == !$past(disk_change) && host_rdata_oe == 8'h80;
    endproperty
    a_change_bit: assert property (p_change_bit) else $error("disk change bit wrong");

    property p_prescale;
        @(posedge mclk) disable iff (srst) core_clk_en |=> !core_clk_en [*2];
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescaler faster than divide by 3");

endmodule // fhri_top

// File: tb/fhri_core_model.sv
// Purpose: stand-in for the execution core behind the port
// Assumes: read-direction command, one data byte
// Notes: fixed answers so results are predictable
`timescale 1ns/1ps
module fhri_core_model (
    // clock and launch
    input wire logic mclk,
    input wire logic exec_start,
    // answers
    output logic core_rbyte_valid,
    output logic [7:0] core_rbyte,
    output logic core_done,
    output fhri_pkg::fhri_result_t core_result
);
    import fhri_pkg::*;
    logic [5:0] cnt = 6'h0;
    assign core_rbyte = 8'ha5;
    // raw flags carry bits the port must mask
    assign core_result = '{8'h4f, 8'h7c, 8'h92, 8'h11, 8'h22, 8'h33, 8'h02};
    always @(posedge mclk) begin
        // launch is unknown before reset, keep the count clean
        cnt <= (exec_start === 1'b1) ? 6'h1 : (cnt != 6'h0 ? cnt + 6'h1 : 6'h0);
        core_rbyte_valid <= (cnt == 6'h04);
        core_done <= (cnt == 6'h1e);
    end
endmodule // fhri_core_model

// File: tb/floppy_host_register_interface_tb_top.sv
// Purpose: self-checking bench for the host register port
// Assumes: inputs change at the falling edge
// Notes: reads note expectations, a monitor compares
`timescale 1ns/1ps
module floppy_host_register_interface_tb_top;
    import fhri_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    fhri_host_req_t host_req = '0;
    fhri_drive_in_t drv_in = '0;
    logic disk_change = 1'b0;
    logic irq, dma_req, clk_en, core_rbyte_valid, core_done, exec_start, rd_q;
    logic [7:0] host_rdata, oe, n, core_rbyte, v;
    logic [3:0] seek_busy = 4'h0;
    logic seek_end = 1'b0;
    int div[3] = '{3, 5, 6};
    logic [3:0] motor_on, drive_active;
    fhri_result_t core_result;
    logic [7:0] exp_q[$];
    logic [7:0] res[7] = '{8'h45, 8'h34, 8'h12, 8'h11, 8'h22, 8'h33, 8'h02};
    int err_count = 0;
    int tests_run = 0;
    always #20 mclk = ~mclk;
    fhri_top u_dut (.mclk(mclk), .srst(srst), .host_req(host_req), .host_rdata(host_rdata), .host_rdata_oe(oe),
        .dma_req(dma_req), .irq(irq), .drv_in(drv_in), .disk_change(disk_change), .motor_on(motor_on),
        .drive_active(drive_active), .unit_bit0(), .unit_bit1(), .side_select_output(), .core_clk_en(clk_en),
        .core_reset(), .exec_start(exec_start), .exec_cmd(), .core_overrun(), .core_wbyte_valid(),
        .core_wbyte(), .core_rbyte_valid(core_rbyte_valid), .core_rbyte(core_rbyte), .core_wreq(1'b0),
        .core_done(core_done), .core_result(core_result), .core_seek_busy(seek_busy), .core_seek_end(seek_end));
    fhri_core_model u_core (.mclk(mclk), .exec_start(exec_start), .core_rbyte_valid(core_rbyte_valid),
        .core_rbyte(core_rbyte), .core_done(core_done), .core_result(core_result));
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            err_count++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
        @(negedge mclk);
        host_req <= '{rd: ~w, wr: w, dack: host_req.dack, addr: a, wdata: d};
        @(negedge mclk);
        host_req.rd <= 1'b0;
        host_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        acc(1'b0, a, 8'h00);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge mclk) rd_q <= host_req.rd & ~srst;
    always @(negedge mclk) if (rd_q && exp_q.size() > 0) check(host_rdata, exp_q.pop_front());
    // generous bound; the sequence needs about 350 cycles
    initial begin
        #200000;
        err_count++;
        results();
    end
    initial begin
        v = 8'($urandom(78));
        repeat (8) @(negedge mclk);
        srst <= 1'b0;
        rd(FHRI_MSR_ADDR, 8'h80);
        acc(1'b1, FHRI_MSR_ADDR, 8'h08);
        rd(FHRI_MSR_ADDR, 8'h80);
        for (int i = 0; i < 4; i++) begin
            // keep reset bit low, select drive i
            v = (8'($urandom) & 8'hf8) | 8'(i);
            acc(1'b1, FHRI_DOR_ADDR, v);
            @(negedge mclk);
            check({4'h0, motor_on}, {4'h0, v[7:4]});
            check({4'h0, drive_active}, {4'h0, v[4 + i] ? 4'(1 << i) : 4'h0});
            disk_change = v[7];
            rd(FHRI_RATE_ADDR, {~v[7], 7'h00});
            check(oe, 8'h80);
        end
        drv_in = 5'($urandom);
        acc(1'b1, FHRI_DOR_ADDR, 8'h29);
        acc(1'b1, FHRI_DATA_ADDR, {3'h0, FHRI_OP_SENSE_DRIVE});
        acc(1'b1, FHRI_DATA_ADDR, 8'h05);
        rd(FHRI_MSR_ADDR, 8'hd0);
        // side select stays low until a command launches
        rd(FHRI_DATA_ADDR, {drv_in, 3'h1});
        acc(1'b1, FHRI_DATA_ADDR, 8'h00);
        rd(FHRI_DATA_ADDR, FHRI_ST0_INVALID);
        rd(FHRI_MSR_ADDR, 8'h80);
        seek_busy = 4'($urandom) | 4'h1;
        repeat (2) @(negedge mclk);
        rd(FHRI_MSR_ADDR, {4'h0, seek_busy});
        acc(1'b1, FHRI_DATA_ADDR, {3'h0, FHRI_OP_SENSE_INT});
        seek_busy = 4'h0;
        seek_end = 1'b1;
        @(negedge mclk);
        seek_end = 1'b0;
        repeat (2) @(negedge mclk);
        rd(FHRI_MSR_ADDR, 8'h80);
        check({7'h0, irq}, 8'h01);
        acc(1'b1, FHRI_DATA_ADDR, {3'h0, FHRI_OP_SENSE_INT});
        rd(FHRI_DATA_ADDR, 8'h47);
        rd(FHRI_DATA_ADDR, 8'h11);
        // m is the non-dma bit given to specify: interrupt pass, then dma pass
        for (int m = 1; m >= 0; m--) begin
            acc(1'b1, FHRI_DATA_ADDR, {3'h0, FHRI_OP_SPECIFY});
            acc(1'b1, FHRI_DATA_ADDR, 8'h00);
            acc(1'b1, FHRI_DATA_ADDR, 8'(m));
            acc(1'b1, FHRI_DATA_ADDR, {3'h0, FHRI_OP_READ});
            repeat (8) acc(1'b1, FHRI_DATA_ADDR, 8'h05);
            for (int i = 0; i < 40 && (m ? irq : dma_req) !== 1'b1; i++) @(negedge mclk);
            check({6'h0, dma_req, irq}, m ? 8'h01 : 8'h02);
            rd(FHRI_MSR_ADDR, m ? 8'hf0 : 8'hd0);
            host_req.dack <= ~m[0];
            // acknowledge alone must reach the data port
            rd(m ? FHRI_DATA_ADDR : FHRI_MSR_ADDR, 8'ha5);
            @(negedge mclk);
            host_req.dack <= 1'b0;
            // ready flips mid-execution in the dma pass
            if (m == 0) drv_in.drive_ready_input = ~drv_in.drive_ready_input;
            check({6'h0, dma_req, irq}, 8'h00);
            for (int i = 0; i < 60 && irq !== 1'b1; i++) @(negedge mclk);
            check({7'h0, irq}, 8'h01);
            rd(FHRI_MSR_ADDR, 8'hd0);
            foreach (res[i]) rd(FHRI_DATA_ADDR, res[i] | ((i == 0 && m == 0) ? 8'h80 : 8'h00));
        end
        rd(FHRI_MSR_ADDR, 8'h80);
        foreach (div[k]) begin
            acc(1'b1, FHRI_RATE_ADDR, 8'(k));
            repeat (12) @(negedge mclk);
            n = 8'h0;
            repeat (30) begin
                @(negedge mclk);
                n = n + {7'h0, clk_en};
            end
            check(n, 8'(30 / div[k]));
        end
        results();
    end
endmodule // floppy_host_register_interface_tb_top
